// *** shared/irqz_consts.vh ***
// Register offsets, field positions, reset values and timing counts
`ifndef IRQZ_CONSTS_VH
`define IRQZ_CONSTS_VH

`define IRQZ_OFS_COUNT2 8'h00
`define IRQZ_OFS_MASK0 8'h04
`define IRQZ_OFS_STAT0 8'h08
`define IRQZ_OFS_COMMAND_DATA_OUTPUT_REGISTER 8'h0C
`define IRQZ_OFS_SERIAL_POLL_MODE_REGISTER 8'h10
`define IRQZ_OFS_CTRL 8'h14
`define IRQZ_OFS_LINES 8'h18

`define IRQZ_MASK0_RESET 8'h80
`define IRQZ_MASK0_WMASK 8'hED
`define IRQZ_COUNT2_RESET 8'h80
`define IRQZ_COUNT2_WMASK 8'h21

`define IRQZ_B_GLOBAL 7
`define IRQZ_B_STATUS_BYTE_OUT_FLAG 6
`define IRQZ_B_NL 5
`define IRQZ_B_EOS 4
`define IRQZ_B_IFC 3
`define IRQZ_B_ATN 2
`define IRQZ_B_SYNC 0
`define IRQZ_B_SLOW 5
`define IRQZ_B_MODIFIER 0
`define IRQZ_B_RSV 6

`define IRQZ_NEWLINE 7'h0A

`define IRQZ_CLK_PERIOD_NS 10
`define IRQZ_SLOW_NS 400
`define IRQZ_SLOW_CYC ((`IRQZ_SLOW_NS + `IRQZ_CLK_PERIOD_NS - 1) / `IRQZ_CLK_PERIOD_NS)

`define IRQZ_RESP_OKAY 2'b00
`define IRQZ_RESP_SLVERR 2'b10

`endif

// *** core/irqz_status_zero.v ***
// Status/mask register pair zero, slow-handshake filter and AXI4-Lite slave
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "irqz_consts.vh"

// Notes on behaviour
// - With slow handshake on, NRFD/NDAC release counts only after 400 ns steady.
// - Modifier bit 0 of count register two changes meaning of frequency bits.
// - Status bits set and clear independently of mask enables, except the set of bit 6 and the set and clear of bit 4 (mask bits 6 and 5).
// - Status set arising during a status read waits until the read ends.
// - Reset clears mask register except global enable, which becomes one.
// - Interrupt requested when a status condition meets its set enable.
// - Global enable at mask bit 7 gates the interrupt pin.
// - Status bit 7 mirrors nba, set by every write to the output register that enables byte lane 0.
// - nba clears on pon, nbaf, NTNL with SIDS, or STRS.
// - Status-byte-out enable low: rsv in serial poll register requests service.
// - Enable high: rsv only by reqt; host writes poll response byte.
// - Status-byte-out flag sets on enable and SPAS; clears pon, poll write, no SPAS.
// - New-line flag sets on accepted newline; clears on pon or other byte.
// - Mask register holds bits 7,6,5,3,2,0; bits 4 and 1 read zero.
// - Status register bit layout; bit 1 reads zero here.
// - New-line end enable makes newline an end-of-string byte, as EOI.
// - Interface-clear flag sets on IFC; clears pon, read unless inhibited, command.
// - Attention flag sets on ATN; clears pon, read unless inhibited, command.
// - Sync flag sets on handshake completion; interrupts with its enable.
module irqz_status_zero (
	input wire CORE_CLK,
	input wire RESET,
	input wire CLK_EN,
	input wire [7:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output wire S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output wire S_AXI_WREADY,
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [7:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output wire S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY,
	input wire PON,
	input wire NBAF,
	input wire NTNL,
	input wire SIDS,
	input wire STRS,
	input wire SPAS,
	input wire LACS,
	input wire ACDS,
	input wire [7:0] DIO_IN,
	input wire REOS_EOS_MATCH,
	input wire IFC_LINE,
	input wire ATN_LINE,
	input wire HANDSHAKE_DONE,
	input wire NRFD_LINE,
	input wire NDAC_LINE,
	input wire REQT_CMD,
	output reg NRFD_FILT,
	output reg NDAC_FILT,
	output reg COUNT_MODIFIER,
	output reg SLOW_ENABLE,
	output reg [7:0] COMMAND_DATA_OUTPUT_REGISTER_DATA,
	output reg [7:0] SPOLL_BYTE,
	output reg RSV_REQUEST,
	output reg END_DETECT,
	output reg INT_OUT
);

////////////////////////////////////////////////////////////////////////////////

function [7:0] lane_merge;
	input [7:0] old;
	input [31:0] wd;
	input [3:0] strb;
	begin
		lane_merge = strb[0] ? wd[7:0] : old;
	end
endfunction

function [7:0] word_addr;
	input [7:0] a;
	begin
		word_addr = {a[7:2], 2'b00};
	end
endfunction

// Rounded up so the release hold never falls short of the required time
localparam integer SLOW_CYC_I = `IRQZ_SLOW_CYC;
localparam [5:0] SLOW_CYC = SLOW_CYC_I[5:0];

reg [7:0] mask0_ff;
reg [7:0] count2_ff;
reg [7:0] status_ff;
reg [7:0] serial_poll_mode_register_ff;
reg status_clear_inhibit_ff;
reg [7:0] pend_ff;
reg ifc_q_ff;
reg atn_q_ff;
reg aw_ff;
reg w_ff;
reg [7:0] awaddr_ff;
reg [31:0] wdata_ff;
reg [3:0] wstrb_ff;
reg [7:0] nxt_status;
reg [7:0] nxt_pend;
reg [7:0] set_ev;
reg [7:0] clr_ev;
reg rsv_lvl_ff;

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave: address and data latched separately, response after both

// Readies drop while frozen so no beat is taken and then lost
assign S_AXI_AWREADY = CLK_EN && !aw_ff && !S_AXI_BVALID;
assign S_AXI_WREADY = CLK_EN && !w_ff && !S_AXI_BVALID;
assign S_AXI_ARREADY = CLK_EN && !S_AXI_RVALID;

wire do_write = aw_ff && w_ff && !S_AXI_BVALID;
wire do_read = S_AXI_ARVALID && S_AXI_ARREADY;
wire rd_stat = do_read && (word_addr(S_AXI_ARADDR) == `IRQZ_OFS_STAT0);
wire wr_sel_command_data_output_register = do_write && (awaddr_ff == `IRQZ_OFS_COMMAND_DATA_OUTPUT_REGISTER) && wstrb_ff[0];
wire wr_sel_serial_poll_mode_register = do_write && (awaddr_ff == `IRQZ_OFS_SERIAL_POLL_MODE_REGISTER) && wstrb_ff[0];
wire wr_ctrl = do_write && (awaddr_ff == `IRQZ_OFS_CTRL);
wire clr_ifc_cmd = wr_ctrl && wstrb_ff[0] && wdata_ff[1];
wire clr_atn_cmd = wr_ctrl && wstrb_ff[0] && wdata_ff[2];

wire known_w = (awaddr_ff == `IRQZ_OFS_COUNT2) || (awaddr_ff == `IRQZ_OFS_MASK0) ||
	(awaddr_ff == `IRQZ_OFS_COMMAND_DATA_OUTPUT_REGISTER) || (awaddr_ff == `IRQZ_OFS_SERIAL_POLL_MODE_REGISTER) ||
	(awaddr_ff == `IRQZ_OFS_CTRL);

always @(posedge CORE_CLK) begin
	if (RESET) begin
		aw_ff <= 1'b0;
		w_ff <= 1'b0;
		awaddr_ff <= 8'h00;
		wdata_ff <= 32'h00000000;
		wstrb_ff <= 4'h0;
		S_AXI_BVALID <= 1'b0;
		S_AXI_BRESP <= 2'b00;
		S_AXI_RVALID <= 1'b0;
		S_AXI_RRESP <= 2'b00;
		S_AXI_RDATA <= 32'h00000000;
	end else if (CLK_EN) begin
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_ff <= 1'b1;
			awaddr_ff <= word_addr(S_AXI_AWADDR);
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_ff <= 1'b1;
			wdata_ff <= S_AXI_WDATA;
			wstrb_ff <= S_AXI_WSTRB;
		end
		if (do_write) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP <= known_w ? `IRQZ_RESP_OKAY : `IRQZ_RESP_SLVERR;
		end else if (S_AXI_BVALID && S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
		if (do_read) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RRESP <= `IRQZ_RESP_OKAY;
			case (word_addr(S_AXI_ARADDR))
				`IRQZ_OFS_STAT0: begin
					S_AXI_RDATA <= {24'h000000, status_ff};
				end
				`IRQZ_OFS_LINES: begin
					S_AXI_RDATA <= {28'h0000000, SLOW_ENABLE, NDAC_FILT, NRFD_FILT, status_clear_inhibit_ff};
				end
				`IRQZ_OFS_COUNT2, `IRQZ_OFS_MASK0, `IRQZ_OFS_COMMAND_DATA_OUTPUT_REGISTER, `IRQZ_OFS_SERIAL_POLL_MODE_REGISTER,
				`IRQZ_OFS_CTRL: begin
					// Write-only registers read as zero
					S_AXI_RDATA <= 32'h00000000;
				end
				default: begin
					S_AXI_RDATA <= 32'h00000000;
					S_AXI_RRESP <= `IRQZ_RESP_SLVERR;
				end
			endcase
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Write-only control registers

always @(posedge CORE_CLK) begin
	if (RESET) begin
		mask0_ff <= `IRQZ_MASK0_RESET;
		count2_ff <= `IRQZ_COUNT2_RESET;
		serial_poll_mode_register_ff <= 8'h00;
		COMMAND_DATA_OUTPUT_REGISTER_DATA <= 8'h00;
		status_clear_inhibit_ff <= 1'b0;
	end else if (CLK_EN && do_write) begin
		case (awaddr_ff)
			`IRQZ_OFS_MASK0: begin
				mask0_ff <= lane_merge(mask0_ff, wdata_ff, wstrb_ff) & `IRQZ_MASK0_WMASK;
			end
			`IRQZ_OFS_COUNT2: begin
				count2_ff <= (lane_merge(count2_ff, wdata_ff, wstrb_ff) & `IRQZ_COUNT2_WMASK) |
					`IRQZ_COUNT2_RESET;
			end
			`IRQZ_OFS_COMMAND_DATA_OUTPUT_REGISTER: begin
				COMMAND_DATA_OUTPUT_REGISTER_DATA <= lane_merge(COMMAND_DATA_OUTPUT_REGISTER_DATA, wdata_ff, wstrb_ff);
			end
			`IRQZ_OFS_SERIAL_POLL_MODE_REGISTER: begin
				serial_poll_mode_register_ff <= lane_merge(serial_poll_mode_register_ff, wdata_ff, wstrb_ff);
			end
			`IRQZ_OFS_CTRL: begin
				if (wstrb_ff[0]) begin
					status_clear_inhibit_ff <= wdata_ff[0];
				end
			end
			default: begin
				mask0_ff <= mask0_ff;
			end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Slow-handshake release filter for NRFD and NDAC

// Assertion passes at once; release needs a steady run when slow mode is on
reg [5:0] nrfd_cnt_ff;
reg [5:0] ndac_cnt_ff;

always @(posedge CORE_CLK) begin
	if (RESET) begin
		nrfd_cnt_ff <= 6'h00;
		ndac_cnt_ff <= 6'h00;
		NRFD_FILT <= 1'b0;
		NDAC_FILT <= 1'b0;
		SLOW_ENABLE <= 1'b0;
		COUNT_MODIFIER <= 1'b0;
	end else if (CLK_EN) begin
		SLOW_ENABLE <= count2_ff[`IRQZ_B_SLOW];
		COUNT_MODIFIER <= count2_ff[`IRQZ_B_MODIFIER];
		if (NRFD_LINE) begin
			nrfd_cnt_ff <= 6'h00;
			NRFD_FILT <= 1'b1;
		end else if (!count2_ff[`IRQZ_B_SLOW] || nrfd_cnt_ff >= SLOW_CYC - 6'h01) begin
			NRFD_FILT <= 1'b0;
		end else begin
			nrfd_cnt_ff <= nrfd_cnt_ff + 6'h01;
		end
		if (NDAC_LINE) begin
			ndac_cnt_ff <= 6'h00;
			NDAC_FILT <= 1'b1;
		end else if (!count2_ff[`IRQZ_B_SLOW] || ndac_cnt_ff >= SLOW_CYC - 6'h01) begin
			NDAC_FILT <= 1'b0;
		end else begin
			ndac_cnt_ff <= ndac_cnt_ff + 6'h01;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Status register zero

wire newline_hit = (DIO_IN[6:0] == `IRQZ_NEWLINE);
wire accept = LACS && ACDS;

always @* begin
	set_ev = 8'h00;
	clr_ev = 8'h00;
	set_ev[7] = wr_sel_command_data_output_register;
	clr_ev[7] = PON || NBAF || (NTNL && SIDS) || STRS;
	// Level set outlasts a poll-register write while the poll is active
	set_ev[`IRQZ_B_STATUS_BYTE_OUT_FLAG] = mask0_ff[`IRQZ_B_STATUS_BYTE_OUT_FLAG] && SPAS;
	clr_ev[`IRQZ_B_STATUS_BYTE_OUT_FLAG] = PON || wr_sel_serial_poll_mode_register || !SPAS;
	set_ev[`IRQZ_B_NL] = accept && newline_hit;
	clr_ev[`IRQZ_B_NL] = PON || (accept && !newline_hit);
	set_ev[`IRQZ_B_EOS] = accept && (REOS_EOS_MATCH ||
		(mask0_ff[`IRQZ_B_NL] && newline_hit));
	clr_ev[`IRQZ_B_EOS] = PON || (accept && !set_ev[`IRQZ_B_EOS]);
	set_ev[`IRQZ_B_IFC] = IFC_LINE && !ifc_q_ff;
	clr_ev[`IRQZ_B_IFC] = PON || (rd_stat && !status_clear_inhibit_ff) || clr_ifc_cmd;
	set_ev[`IRQZ_B_ATN] = ATN_LINE && !atn_q_ff;
	clr_ev[`IRQZ_B_ATN] = PON || (rd_stat && !status_clear_inhibit_ff) || clr_atn_cmd;
	set_ev[`IRQZ_B_SYNC] = HANDSHAKE_DONE;
	clr_ev[`IRQZ_B_SYNC] = PON || accept || wr_sel_command_data_output_register;
	// Sets arising in the read cycle are parked and applied one cycle later
	nxt_pend = rd_stat ? (set_ev | pend_ff) : 8'h00;
	nxt_status = rd_stat ? (status_ff & ~clr_ev) :
		((status_ff & ~clr_ev) | set_ev | pend_ff);
	nxt_status[1] = 1'b0;
end

always @(posedge CORE_CLK) begin
	if (RESET) begin
		status_ff <= 8'h00;
		pend_ff <= 8'h00;
		ifc_q_ff <= 1'b0;
		atn_q_ff <= 1'b0;
		END_DETECT <= 1'b0;
	end else if (CLK_EN) begin
		status_ff <= nxt_status;
		pend_ff <= nxt_pend & ~{8{PON}};
		ifc_q_ff <= IFC_LINE;
		atn_q_ff <= ATN_LINE;
		END_DETECT <= set_ev[`IRQZ_B_EOS];
	end
end

////////////////////////////////////////////////////////////////////////////////
// Service request, serial poll byte and interrupt output

always @(posedge CORE_CLK) begin
	if (RESET) begin
		rsv_lvl_ff <= 1'b0;
		RSV_REQUEST <= 1'b0;
		SPOLL_BYTE <= 8'h00;
		INT_OUT <= 1'b0;
	end else if (CLK_EN) begin
		if (mask0_ff[`IRQZ_B_STATUS_BYTE_OUT_FLAG]) begin
			if (REQT_CMD) begin
				rsv_lvl_ff <= 1'b1;
			end else if (SPAS) begin
				rsv_lvl_ff <= 1'b0;
			end
		end else begin
			rsv_lvl_ff <= 1'b0;
		end
		RSV_REQUEST <= mask0_ff[`IRQZ_B_STATUS_BYTE_OUT_FLAG] ? rsv_lvl_ff :
			serial_poll_mode_register_ff[`IRQZ_B_RSV];
		SPOLL_BYTE <= serial_poll_mode_register_ff;
		// Bit 5 of the mask is an end enable, not an interrupt enable
		INT_OUT <= mask0_ff[`IRQZ_B_GLOBAL] &&
			(|(status_ff & mask0_ff & 8'h4D));
	end
end

endmodule
`default_nettype wire

// *** tb/irqz_status_zero_assertions.sv ***
// Checker for the register bus, handshake filter and interrupt pin
`timescale 1ns/1ps
`default_nettype none
`include "irqz_consts.vh"
module irqz_chk (
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic NRFD_LINE,
	input wire logic NRFD_FILT,
	input wire logic SLOW_ENABLE,
	input wire logic [7:0] SPOLL_BYTE,
	input wire logic INT_OUT
);
	logic [7:0] wd_ff;
	always_ff @(posedge CORE_CLK) if (S_AXI_WVALID && S_AXI_WREADY) wd_ff <= S_AXI_WDATA[7:0];
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	sequence wr_serial_poll_mode_register;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
			&& S_AXI_AWADDR == `IRQZ_OFS_SERIAL_POLL_MODE_REGISTER;
	endsequence
	////////////////////////////////////////
	a_bresp_held: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped");
	a_rdata_held: assert property (S_AXI_RVALID && !S_AXI_RREADY
		|=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
	a_read_answered: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read not answered");
	a_unmapped_error: assert property (S_AXI_ARVALID && S_AXI_ARREADY
		&& {S_AXI_ARADDR[7:2], 2'b00} > `IRQZ_OFS_LINES |=> S_AXI_RRESP == `IRQZ_RESP_SLVERR
		&& S_AXI_RDATA == 32'h0) else $error("unmapped read accepted");
	a_slow_hold: assert property (SLOW_ENABLE && NRFD_FILT && $fell(NRFD_LINE)
		|=> NRFD_FILT [*8]) else $error("filter released early");
	a_fast_release: assert property (!SLOW_ENABLE && !$past(SLOW_ENABLE)
		&& !NRFD_LINE && !$past(NRFD_LINE) |-> !NRFD_FILT) else $error("filter stuck");
	a_spoll_load: assert property (wr_serial_poll_mode_register |-> ##[1:4] SPOLL_BYTE == wd_ff)
		else $error("poll byte not loaded");
	a_int_after_reset: assert property ($fell(RESET) |-> !INT_OUT)
		else $error("interrupt out of reset");
endmodule
bind irqz_status_zero irqz_chk chk_u (.CORE_CLK, .RESET, .S_AXI_AWADDR, .S_AXI_AWVALID,
	.S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID,
	.S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
	.S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .NRFD_LINE, .NRFD_FILT, .SLOW_ENABLE,
	.SPOLL_BYTE, .INT_OUT);
`default_nettype wire

// *** tb/irqz_bus_model.sv ***
// Instrument-bus partner: listener acceptance and control line pulses
`timescale 1ns/1ps
`default_nettype none
module irqz_bus_model (
	input wire logic clk,
	output logic lacs = 1'h0,
	output logic acds = 1'h0,
	output logic [7:0] dio = 8'h00,
	output logic [3:0] ctl = 4'h0
);
	task automatic accept(input logic [7:0] b);
		@(posedge clk);
		dio <= b;
		lacs <= 1'h1;
		acds <= 1'h1;
		@(posedge clk);
		lacs <= 1'h0;
		acds <= 1'h0;
		dio <= ~b; // Released lines must not look like the last byte
	endtask
	task automatic pulse(input logic [3:0] m, input int n);
		@(posedge clk);
		ctl <= m;
		repeat (n) @(posedge clk);
		ctl <= 4'h0;
	endtask
endmodule
`default_nettype wire

// *** tb/ieee488_irq_status_zero_tb.sv ***
// Register-level bench for status/mask pair zero
`timescale 1ns/1ps
`default_nettype none
`include "irqz_consts.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module ieee488_irq_status_zero_tb;
	logic clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, rdat, lm = 8'h00;
	logic [31:0] wdata = 32'h0, clr = {8'h20, 8'h10, 8'h0C, 8'h02};
	logic [3:0] strb = 4'hF, ctl;
	logic [1:0] resp;
	logic lacs, acds;
	logic [7:0] dio;
	wire awrdy, wrdy, bv, arrdy, rv, filt, ndf, eod, slow, modif, rsv, intr;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] spb, cdo;
	integer error_cnt = 0, checks = 0, i;
	initial forever #5 clk = ~clk;
	irqz_bus_model bus (.clk(clk), .lacs(lacs), .acds(acds), .dio(dio), .ctl(ctl));
	irqz_status_zero dut_u (.CORE_CLK(clk), .RESET(rst), .CLK_EN(1'h1),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
		.PON(lm[5]), .NBAF(lm[4]), .NTNL(lm[3]), .SIDS(lm[2]), .STRS(lm[1]), .SPAS(lm[0]),
		.LACS(lacs), .ACDS(acds), .DIO_IN(dio), .REOS_EOS_MATCH(lm[6]), .IFC_LINE(ctl[0]),
		.ATN_LINE(ctl[1]), .HANDSHAKE_DONE(ctl[3]), .NRFD_LINE(ctl[2]), .NDAC_LINE(ctl[2]),
		.REQT_CMD(lm[7]), .NRFD_FILT(filt), .NDAC_FILT(ndf), .COUNT_MODIFIER(modif),
		.SLOW_ENABLE(slow), .COMMAND_DATA_OUTPUT_REGISTER_DATA(cdo), .SPOLL_BYTE(spb), .RSV_REQUEST(rsv),
		.END_DETECT(eod), .INT_OUT(intr));
	////////////////////////////////////////
	task wrap_up;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
		integer n;
		@(posedge clk);
		awaddr <= a;
		araddr <= a;
		wdata <= {24'h0, d};
		strb <= s;
		{awv, wv, bready} <= {3{wr}};
		{arv, rready} <= {2{!wr}};
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awv && awrdy) awv <= 1'h0;
			if (wv && wrdy) wv <= 1'h0;
			if (arv && arrdy) arv <= 1'h0;
			if (bv || rv) begin
				{bready, rready} <= 2'h0;
				rdat = rdata[7:0];
				resp = wr ? bresp : rresp;
				n = 99;
			end
		end
		if (n < 99) begin
			error_cnt++;
			wrap_up();
		end
	endtask
	task chk_rd(input logic [7:0] e);
		xfer(1'h0, `IRQZ_OFS_STAT0, 8'h00, 4'h0);
		`CHK(rdat, e)
	endtask
	task loc(input logic [7:0] v, input int n);
		@(posedge clk);
		lm <= v;
		repeat (n) @(posedge clk);
	endtask
	////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		chk_rd(8'h00);
		`CHK(intr, 1'h0)
		xfer(1'h0, `IRQZ_OFS_MASK0, 8'h00, 4'h0);
		`CHK(rdat, 8'h00)
		xfer(1'h0, 8'h1C, 8'h00, 4'h0);
		`CHK(resp, `IRQZ_RESP_SLVERR)
		xfer(1'h1, 8'h1C, 8'h00, 4'h1);
		`CHK(resp, `IRQZ_RESP_SLVERR)
		for (i = 0; i < 4; i++) begin
			xfer(1'h1, `IRQZ_OFS_COMMAND_DATA_OUTPUT_REGISTER, 8'hA5, 4'h1);
			chk_rd(8'h80);
			`CHK(cdo, 8'hA5)
			loc(clr[8*i +: 8], 1);
			loc(8'h00, 1);
			chk_rd(8'h00);
		end
		xfer(1'h1, `IRQZ_OFS_MASK0, 8'h08, 4'hF);
		`CHK(resp, `IRQZ_RESP_OKAY)
		bus.pulse(4'h1, 5);
		`CHK(intr, 1'h0)
		chk_rd(8'h08);
		chk_rd(8'h00);
		// Clear inhibit on: reads keep the flag, only the command clears it
		xfer(1'h1, `IRQZ_OFS_CTRL, 8'h01, 4'h1);
		bus.pulse(4'h1, 2);
		chk_rd(8'h08);
		chk_rd(8'h08);
		xfer(1'h0, `IRQZ_OFS_LINES, 8'h00, 4'h0);
		`CHK(rdat, 8'h01)
		xfer(1'h1, `IRQZ_OFS_CTRL, 8'h03, 4'h1);
		chk_rd(8'h00);
		xfer(1'h1, `IRQZ_OFS_CTRL, 8'h00, 4'h1);
		xfer(1'h1, `IRQZ_OFS_MASK0, 8'h8C, 4'h1);
		bus.pulse(4'h2, 5);
		`CHK(intr, 1'h1)
		chk_rd(8'h04);
		// Attention rises on the very edge that takes the status read
		fork
			bus.pulse(4'h2, 3);
			chk_rd(8'h00);
		join
		chk_rd(8'h04);
		loc(8'h00, 3);
		`CHK(intr, 1'h0)
		// Enable low: rsv bit alone requests service
		xfer(1'h1, `IRQZ_OFS_MASK0, 8'h00, 4'hF);
		xfer(1'h1, `IRQZ_OFS_SERIAL_POLL_MODE_REGISTER, 8'h40, 4'hF);
		loc(8'h00, 3);
		`CHK(rsv, 1'h1)
		xfer(1'h1, `IRQZ_OFS_MASK0, 8'h40, 4'hF);
		loc(8'h00, 3);
		`CHK(rsv, 1'h0)
		loc(8'h80, 1);
		loc(8'h00, 3);
		`CHK(rsv, 1'h1)
		loc(8'h01, 3);
		chk_rd(8'h40);
		xfer(1'h1, `IRQZ_OFS_SERIAL_POLL_MODE_REGISTER, 8'h47, 4'hF);
		loc(8'h01, 3);
		`CHK(spb, 8'h47)
		loc(8'h00, 3);
		chk_rd(8'h00);
		xfer(1'h1, `IRQZ_OFS_MASK0, 8'h20, 4'h1);
		bus.accept(`IRQZ_NEWLINE);
		loc(8'h00, 0);
		`CHK(eod, 1'h1)
		chk_rd(8'h30);
		bus.pulse(4'h8, 1);
		chk_rd(8'h31);
		bus.accept(8'h41);
		loc(8'h00, 0);
		`CHK(eod, 1'h0)
		chk_rd(8'h00);
		xfer(1'h1, `IRQZ_OFS_COUNT2, 8'hA1, 4'hF);
		loc(8'h00, 1);
		`CHK({slow, modif}, 2'h3)
		bus.pulse(4'h4, 5);
		// Lines released 400 ns ago at this edge: filter must still hold
		loc(8'h00, 39);
		`CHK({filt, ndf}, 2'h3)
		loc(8'h00, 15);
		`CHK({filt, ndf}, 2'h0)
		xfer(1'h1, `IRQZ_OFS_COUNT2, 8'h80, 4'hF);
		bus.pulse(4'h4, 5);
		loc(8'h00, 3);
		`CHK({filt, ndf}, 2'h0)
		wrap_up();
	end
	// Guards against a hung handshake anywhere above
	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		wrap_up();
	end
endmodule
`default_nettype wire
